// ===== hw/serial_link_error_supervisor_pkg.sv
// constants shared by the serial link error supervisor
`default_nettype none
package serial_link_error_supervisor_pkg;
  // clock rate and the millisecond tick
  localparam int CLOCK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;
  // error codes reported or logged
  localparam logic [7:0] CODE_COMM_ERROR = 8'h84;
  localparam logic [7:0] CODE_COMM_TIMEOUT = 8'h85;
  localparam logic [7:0] CODE_NACK = 8'h01;
  // header byte layout
  localparam int HDR_BCAST_BIT = 7;
  localparam logic [6:0] BCAST_ADDR = 7'h00;
  // error log
  localparam int LOG_DEPTH = 8;
  localparam int LOG_IDX_W = 3;
  // stop method used when the comm alarm cuts excitation
  localparam logic [1:0] STOP_IMMEDIATE = 2'h0;
  // reset values and the 4-bit saturation limit
  localparam logic [15:0] BIT_CNT_RST = 16'h0000;
  localparam logic [3:0] ERR_CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] MS_CNT_RST = 16'h0000;
  localparam logic [3:0] SAT4_MAX = 4'hF;
  // character format: 8 data bits, one stop bit
  localparam logic [3:0] CHAR_BITS = 4'h9;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
  typedef enum logic {FR_IDLE, FR_RECV} frame_state_t;
endpackage : serial_link_error_supervisor_pkg
`default_nettype wire

// ===== hw/serial_char_rx.sv
// asynchronous character receiver, 8 data bits and one stop bit
`default_nettype none
module serial_char_rx
  import serial_link_error_supervisor_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // synchronised line and bit time
  input wire logic rxLevel,
  input wire logic [15:0] bitCycles,
  // received character
  output logic charValid,
  output logic [7:0] charData,
  output logic charStopBad
);
  rx_state_t state_ff;
  logic [15:0] cnt_ff;
  logic [3:0] bitNo_ff;
  logic [8:0] shift_ff;
  logic valid_ff;
  logic [7:0] data_ff;
  logic stopBad_ff;

  // counts run N down to 0, so load one less than the span wanted
  wire logic [15:0] halfBit = {1'b0, bitCycles[15:1]} - 16'h0001;
  wire logic [15:0] bitReload = bitCycles - 16'h0001;
  wire logic cntDone = (cnt_ff == BIT_CNT_RST);
  wire logic [15:0] cntDec = cnt_ff - 16'h0001;
  wire logic lastBit = (bitNo_ff == CHAR_BITS - 4'h1);

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_ff <= RX_IDLE;
      cnt_ff <= BIT_CNT_RST;
      bitNo_ff <= 4'h0;
      shift_ff <= 9'h000;
      valid_ff <= 1'b0;
      data_ff <= BYTE_RST;
      stopBad_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      unique case (state_ff)
        RX_IDLE:
        begin
          if (!rxLevel)
          begin
            state_ff <= RX_START;
            cnt_ff <= halfBit;
          end
        end
        RX_START:
        begin
          if (cntDone)
          begin
            // a glitch shorter than half a bit is not a start
            state_ff <= rxLevel ? RX_IDLE : RX_BITS;
            cnt_ff <= bitReload;
            bitNo_ff <= 4'h0;
          end
          else
            cnt_ff <= cntDec;
        end
        RX_BITS:
        begin
          if (cntDone)
          begin
            shift_ff <= {rxLevel, shift_ff[8:1]};
            cnt_ff <= bitReload;
            bitNo_ff <= bitNo_ff + 4'h1;
            if (lastBit)
            begin
              state_ff <= RX_IDLE;
              valid_ff <= 1'b1;
              data_ff <= shift_ff[8:1];
              stopBad_ff <= !rxLevel;
            end
          end
          else
            cnt_ff <= cntDec;
        end
      endcase
    end
  end

  assign charValid = valid_ff;
  assign charData = data_ff;
  assign charStopBad = stopBad_ff;
endmodule : serial_char_rx
`default_nettype wire

// ===== hw/serial_link_error_supervisor.sv
// receive-side error supervision of the slave serial link
//
// Operation
// - single comm error raises warning, motion continues
// - error-free frame clears the warning
// - consecutive errors reaching count raise alarm
// - during comm alarm ignore link, no excitation
// - stop bit zero discards the whole frame
// - receive monitor expiry discards the frame
// - block check mismatch discards the frame
// - broadcast with nonzero address is invalid
// - rejected frames never get a response
// - no traffic within receive period: alarm
// - timeout stops motor by timeout action
// - stop frame decelerates by stop action
// - any alarm drops alarm line, stops motor
// - warning line follows the warning condition
// - discarded frames logged in volatile log
`default_nettype none
module serial_link_error_supervisor
  import serial_link_error_supervisor_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial line
  input wire logic rxPin,
  input wire logic [15:0] bitCycles,
  // settings
  input wire logic [7:0] frameLength,
  input wire logic [7:0] receiveMonitorMs,
  input wire logic [15:0] receivePeriodMs,
  input wire logic [3:0] errAlarmCount,
  input wire logic [1:0] stopAction,
  input wire logic [1:0] timeoutAction,
  // from command handling
  input wire logic stopFrame,
  input wire logic nackEvent,
  input wire logic alarmReset,
  // accepted frames
  output logic frameGood,
  output logic [6:0] frameAddr,
  output logic frameBroadcast,
  output logic respondAllowed,
  // status
  output logic errorPulse,
  output logic [7:0] errorCode,
  output logic warningOutputLine,
  output logic alarmOutputLine,
  output logic commAlarm,
  output logic timeoutAlarm,
  output logic motorExcite,
  output logic motorStopReq,
  output logic [1:0] stopMethod,
  // error log
  input wire logic [2:0] logIndex,
  output logic [7:0] logData,
  output logic [3:0] logCount
);
  function automatic logic [3:0] incSat4(input logic [3:0] v);
    incSat4 = (v == SAT4_MAX) ? v : v + 4'h1;
  endfunction : incSat4
  // line synchroniser, first stage feeds only the second
  logic rxMeta_ff;
  logic rxSync_ff;
  always_ff @(posedge clock)
  begin
    rxMeta_ff <= resetn ? rxPin : 1'b1;
    rxSync_ff <= resetn ? rxMeta_ff : 1'b1;
  end
  logic charValid;
  logic [7:0] charData;
  logic charStopBad;
  serial_char_rx u_char_rx (
    .clock(clock),
    .resetn(resetn),
    .rxLevel(rxSync_ff),
    .bitCycles(bitCycles),
    .charValid(charValid),
    .charData(charData),
    .charStopBad(charStopBad)
  );
  // millisecond tick; coarse, so monitor expiry jitters by one ms
  logic [15:0] tickCnt_ff;
  wire logic tickNow = (tickCnt_ff == 16'(TICK_LEN - 1));
  always_ff @(posedge clock)
  begin
    if (!resetn)
      tickCnt_ff <= MS_CNT_RST;
    else
      tickCnt_ff <= tickNow ? MS_CNT_RST : tickCnt_ff + 16'h0001;
  end
  logic commAlarm_ff;
  logic timeoutAlarm_ff;
  wire logic anyAlarm = commAlarm_ff | timeoutAlarm_ff;
  wire logic charIn = charValid & ~commAlarm_ff;
  // frame assembly state
  frame_state_t fr_ff;
  logic [7:0] byteNo_ff;
  logic [7:0] bcc_ff;
  logic [7:0] header_ff;
  logic [7:0] monMs_ff;
  wire logic isLastByte = (fr_ff == FR_RECV) &&
                          (byteNo_ff + 8'h01 == frameLength);
  wire logic monExpired = (fr_ff == FR_RECV) && tickNow &&
                          (monMs_ff + 8'h01 >= receiveMonitorMs);
  wire logic framingErr = charIn & charStopBad;
  wire logic bccBad = (bcc_ff != charData);
  wire logic hdrBad = header_ff[HDR_BCAST_BIT] &&
                      (header_ff[6:0] != BCAST_ADDR);
  wire logic endGood = charIn & ~charStopBad & isLastByte;
  wire logic frameErr = framingErr | monExpired |
                        (endGood & (bccBad | hdrBad));
  wire logic frameOk = endGood & ~bccBad & ~hdrBad & ~monExpired;
  always_ff @(posedge clock)
  begin
    if (!resetn || commAlarm_ff)
    begin
      fr_ff <= FR_IDLE;
      byteNo_ff <= BYTE_RST;
      bcc_ff <= BYTE_RST;
      header_ff <= BYTE_RST;
      monMs_ff <= BYTE_RST;
    end
    // frame accepted or discarded, wait for next frame
    else if (frameErr || frameOk)
      fr_ff <= FR_IDLE;
    else if (charIn)
    begin
      fr_ff <= FR_RECV;
      byteNo_ff <= (fr_ff == FR_IDLE) ? 8'h01 : byteNo_ff + 8'h01;
      bcc_ff <= (fr_ff == FR_IDLE) ? charData : bcc_ff ^ charData;
      if (fr_ff == FR_IDLE)
      begin
        header_ff <= charData;
        monMs_ff <= BYTE_RST;
      end
    end
    else if (tickNow && fr_ff == FR_RECV)
      monMs_ff <= monMs_ff + 8'h01;
  end
  // accepted frame handed on
  logic frameGood_ff;
  logic [6:0] frameAddr_ff;
  logic frameBcast_ff;
  logic respond_ff;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      frameGood_ff <= 1'b0;
      frameAddr_ff <= 7'h00;
      frameBcast_ff <= 1'b0;
      respond_ff <= 1'b0;
    end
    else
    begin
      frameGood_ff <= frameOk;
      // reply only for accepted unicast frames
      respond_ff <= frameOk & ~header_ff[HDR_BCAST_BIT];
      if (frameOk)
      begin
        frameAddr_ff <= header_ff[6:0];
        frameBcast_ff <= header_ff[HDR_BCAST_BIT];
      end
    end
  end
  // consecutive error counting, warning and comm alarm
  logic [3:0] errCnt_ff;
  logic warning_ff;
  wire logic [3:0] nxt_errCnt = incSat4(errCnt_ff);
  wire logic alarmHit = frameErr && (nxt_errCnt >= errAlarmCount);
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      errCnt_ff <= ERR_CNT_RST;
      warning_ff <= 1'b0;
      commAlarm_ff <= 1'b0;
    end
    else
    begin
      if (frameErr)
        errCnt_ff <= nxt_errCnt;
      else if (frameOk)
        errCnt_ff <= ERR_CNT_RST;
      if (frameErr)
        warning_ff <= 1'b1;
      else if (frameOk)
        warning_ff <= 1'b0;
      // alarm at configured count; set beats reset
      if (alarmHit)
        commAlarm_ff <= 1'b1;
      else if (alarmReset)
        commAlarm_ff <= 1'b0;
    end
  end
  // receive period watchdog, armed by the first good frame
  logic commSeen_ff;
  logic [15:0] idleMs_ff;
  wire logic wdOn = commSeen_ff && (receivePeriodMs != MS_CNT_RST);
  wire logic wdExpire = wdOn && tickNow && !charIn &&
                        (idleMs_ff + 16'h0001 >= receivePeriodMs);
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      commSeen_ff <= 1'b0;
      idleMs_ff <= MS_CNT_RST;
      timeoutAlarm_ff <= 1'b0;
    end
    else
    begin
      if (frameOk)
        commSeen_ff <= 1'b1;
      if (charIn)
        idleMs_ff <= MS_CNT_RST;
      else if (tickNow && wdOn && !timeoutAlarm_ff)
        idleMs_ff <= idleMs_ff + 16'h0001;
      if (wdExpire && !timeoutAlarm_ff)
        timeoutAlarm_ff <= 1'b1;
      else if (alarmReset)
      begin
        timeoutAlarm_ff <= 1'b0;
        commSeen_ff <= 1'b0;
      end
    end
  end
  // error reporting and motor control
  logic errPulse_ff;
  logic [7:0] errCode_ff;
  logic stopReq_ff;
  logic [1:0] stopMethod_ff;
  logic excite_ff;
  wire logic timeoutRise = wdExpire & ~timeoutAlarm_ff;
  wire logic commRise = alarmHit & ~commAlarm_ff;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      errPulse_ff <= 1'b0;
      errCode_ff <= BYTE_RST;
      stopReq_ff <= 1'b0;
      stopMethod_ff <= STOP_IMMEDIATE;
      excite_ff <= 1'b1;
    end
    else
    begin
      errPulse_ff <= frameErr | timeoutRise;
      if (frameErr)
        errCode_ff <= CODE_COMM_ERROR;
      else if (timeoutRise)
        errCode_ff <= CODE_COMM_TIMEOUT;
      stopReq_ff <= commRise | timeoutRise | stopFrame;
      if (commRise)
        stopMethod_ff <= STOP_IMMEDIATE;
      else if (timeoutRise)
        stopMethod_ff <= timeoutAction;
      else if (stopFrame)
        stopMethod_ff <= stopAction;
      excite_ff <= !(commAlarm_ff || commRise);
    end
  end
  // output lines
  logic warnLine_ff;
  logic almLine_ff;
  always_ff @(posedge clock)
  begin
    warnLine_ff <= resetn ? warning_ff : 1'b0;
    almLine_ff <= resetn ? !anyAlarm : 1'b1;
  end
  // volatile error log, cleared only by reset
  logic [7:0] log_ff [LOG_DEPTH];
  logic [LOG_IDX_W-1:0] logWr_ff;
  logic [3:0] logCnt_ff;
  logic [7:0] logData_ff;
  wire logic logEvent = frameErr | nackEvent;
  wire logic [7:0] logCode = frameErr ? CODE_COMM_ERROR : CODE_NACK;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < LOG_DEPTH; i++)
        log_ff[i] <= BYTE_RST;
      logWr_ff <= '0;
      logCnt_ff <= ERR_CNT_RST;
      logData_ff <= BYTE_RST;
    end
    else
    begin
      if (logEvent)
      begin
        log_ff[logWr_ff] <= logCode;
        logWr_ff <= logWr_ff + 3'h1;
        if (logCnt_ff < 4'(LOG_DEPTH))
          logCnt_ff <= logCnt_ff + 4'h1;
      end
      logData_ff <= log_ff[logIndex];
    end
  end
  assign frameGood = frameGood_ff;
  assign frameAddr = frameAddr_ff;
  assign frameBroadcast = frameBcast_ff;
  assign respondAllowed = respond_ff;
  assign errorPulse = errPulse_ff;
  assign errorCode = errCode_ff;
  assign warningOutputLine = warnLine_ff;
  assign alarmOutputLine = almLine_ff;
  assign commAlarm = commAlarm_ff;
  assign timeoutAlarm = timeoutAlarm_ff;
  assign motorExcite = excite_ff;
  assign motorStopReq = stopReq_ff;
  assign stopMethod = stopMethod_ff;
  assign logData = logData_ff;
  assign logCount = logCnt_ff;
endmodule : serial_link_error_supervisor
`default_nettype wire

// ===== sim/serial_link_error_supervisor_props.sv
// concurrent checks on the serial link error supervisor ports
`default_nettype none
module serial_link_error_supervisor_props
  import serial_link_error_supervisor_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // command side
  input wire logic stopFrame,
  // frame results
  input wire logic frameGood,
  input wire logic frameBroadcast,
  input wire logic respondAllowed,
  // status
  input wire logic errorPulse,
  input wire logic [7:0] errorCode,
  input wire logic warningOutputLine,
  input wire logic alarmOutputLine,
  input wire logic commAlarm,
  input wire logic timeoutAlarm,
  input wire logic motorExcite,
  input wire logic motorStopReq,
  input wire logic [1:0] stopMethod
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence sCommErr;
    errorPulse && errorCode == CODE_COMM_ERROR;
  endsequence
  // alarm stop may land with the error or one cycle later
  sequence sHaltNow;
    ##[0:1] (motorStopReq && stopMethod == STOP_IMMEDIATE);
  endsequence
  AST_RESP_ONLY_GOOD:
    assert property (respondAllowed |-> frameGood && !frameBroadcast)
    else $error("response allowed without a good unicast frame");
  AST_WARN_RAISE:
    assert property (sCommErr |=> warningOutputLine)
    else $error("warning line not raised after frame error");
  AST_WARN_CLEAR:
    assert property (frameGood |=> !warningOutputLine)
    else $error("warning line not cleared after good frame");
  AST_ALARM_LINE:
    assert property ($rose(commAlarm) || $rose(timeoutAlarm)
      |=> !alarmOutputLine)
    else $error("alarm line still high after alarm");
  AST_NO_EXCITE:
    assert property (commAlarm |=> !motorExcite)
    else $error("motor excited during comm alarm");
  AST_IGNORE_LINE:
    assert property (commAlarm |-> !frameGood && !respondAllowed)
    else $error("frame accepted during comm alarm");
  AST_ALARM_CAUSE:
    assert property ($rose(commAlarm) |-> sCommErr)
    else $error("comm alarm without a frame error");
  AST_ALARM_HALT:
    assert property ($rose(commAlarm) |-> sHaltNow)
    else $error("comm alarm without immediate stop");
  AST_STOP_FRAME:
    assert property (stopFrame && !commAlarm |=> motorStopReq)
    else $error("stop frame gave no stop request");
  AST_TIMEOUT_CODE:
    assert property ($rose(timeoutAlarm)
      |-> ##[0:1] (errorPulse && errorCode == CODE_COMM_TIMEOUT))
    else $error("timeout alarm without its error code");
endmodule : serial_link_error_supervisor_props
bind serial_link_error_supervisor serial_link_error_supervisor_props
  i_serial_link_error_supervisor_props (
  .clock(clock),
  .resetn(resetn),
  .stopFrame(stopFrame),
  .frameGood(frameGood),
  .frameBroadcast(frameBroadcast),
  .respondAllowed(respondAllowed),
  .errorPulse(errorPulse),
  .errorCode(errorCode),
  .warningOutputLine(warningOutputLine),
  .alarmOutputLine(alarmOutputLine),
  .commAlarm(commAlarm),
  .timeoutAlarm(timeoutAlarm),
  .motorExcite(motorExcite),
  .motorStopReq(motorStopReq),
  .stopMethod(stopMethod)
);
`default_nettype wire

// ===== sim/serial_host_master.sv
// host master model sending frames on the slave serial line
`default_nettype none
module serial_host_master
#(
  parameter int BIT = 4,
  parameter int GAP = 30,
  parameter int MON = 500
)
(
  // clock
  input wire logic clock,
  // serial line, idle high
  output logic rxPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxPin = 1'b1;
  task automatic send_byte(input logic [7:0] b, input logic stopBit);
    logic [9:0] sh;
    sh = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++)
      repeat (BIT) @(negedge clock) rxPin = sh[i];
    @(negedge clock) rxPin = 1'b1;
  endtask : send_byte
  // mode 0 good, 1 bad check, 2 bad stop, 3 header only
  task automatic send_frame(input logic [7:0] hdr, input logic [7:0] dat,
    input int mode);
    send_byte(hdr, 1'b1);
    if (mode != 3)
      send_byte(dat, mode != 2);
    // a framing fault ends the frame, the check would start a new one
    if (mode < 2)
      send_byte(hdr ^ dat ^ {7'h00, mode == 1}, 1'b1);
    repeat (mode != 0 ? MON : GAP) @(negedge clock);
  endtask : send_frame
endmodule : serial_host_master
`default_nettype wire

// ===== sim/serial_link_error_supervisor_tb_top.sv
// self-checking bench for the serial link error supervisor
`default_nettype none
module serial_link_error_supervisor_tb_top
  import serial_link_error_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic rxPin;
  logic [7:0] receiveMonitorMs = 8'h14;
  logic [15:0] receivePeriodMs = 16'h0000;
  logic [1:0] stopAction = 2'h0;
  logic [1:0] timeoutAction = 2'h1;
  logic stopFrame = 1'b0;
  logic nackEvent = 1'b0;
  logic alarmReset = 1'b0;
  logic [2:0] logIndex = 3'h0;
  logic frameGood, frameBroadcast, respondAllowed, errorPulse;
  logic warningOutputLine, alarmOutputLine, commAlarm, timeoutAlarm;
  logic motorExcite, motorStopReq;
  logic [1:0] stopMethod;
  logic [6:0] frameAddr;
  logic [7:0] errorCode, logData, status;
  logic [3:0] logCount;
  logic sawGood, sawResp, sawErr, sawStop;
  int mismatches = 0;
  int total_checks = 0;
  assign status = {1'b0, commAlarm, alarmOutputLine, motorExcite, sawGood,
    sawResp, sawErr, warningOutputLine};
  initial
  begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    sawGood <= sawGood | frameGood;
    sawResp <= sawResp | respondAllowed;
    sawErr <= sawErr | errorPulse;
    sawStop <= sawStop | motorStopReq;
  end
  serial_host_master #(.BIT(4)) i_serial_host_master (
    .clock(clock),
    .rxPin(rxPin)
  );
  serial_link_error_supervisor #(.TICK_LEN(20)) i_serial_link_error_supervisor (
    .clock(clock), .resetn(resetn), .rxPin(rxPin), .bitCycles(16'h0004),
    .frameLength(8'h03), .receiveMonitorMs(receiveMonitorMs),
    .receivePeriodMs(receivePeriodMs), .errAlarmCount(4'h3),
    .stopAction(stopAction), .timeoutAction(timeoutAction),
    .stopFrame(stopFrame),
    .nackEvent(nackEvent), .alarmReset(alarmReset), .frameGood(frameGood),
    .frameAddr(frameAddr), .frameBroadcast(frameBroadcast),
    .respondAllowed(respondAllowed), .errorPulse(errorPulse),
    .errorCode(errorCode), .warningOutputLine(warningOutputLine),
    .alarmOutputLine(alarmOutputLine), .commAlarm(commAlarm),
    .timeoutAlarm(timeoutAlarm), .motorExcite(motorExcite),
    .motorStopReq(motorStopReq), .stopMethod(stopMethod),
    .logIndex(logIndex), .logData(logData), .logCount(logCount)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat,
    input int mode, input logic [7:0] exp);
    @(negedge clock);
    {sawGood, sawResp, sawErr, sawStop} = 4'h0;
    i_serial_host_master.send_frame(hdr, dat, mode);
    check(status, exp);
    $display("frame %h mode %0d done", hdr, mode);
  endtask : frame
  task automatic clear_alarms();
    @(negedge clock) alarmReset = 1'b1;
    @(negedge clock) alarmReset = 1'b0;
    repeat (3) @(negedge clock);
  endtask : clear_alarms
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    frame(8'h05, 8'hA5, 0, 8'h3C);
    check({1'b0, frameAddr}, 8'h05);
    frame(8'h05, 8'hA5, 1, 8'h33);
    check(errorCode, CODE_COMM_ERROR);
    frame(8'h05, 8'h11, 0, 8'h3C);
    frame(8'h05, 8'h22, 2, 8'h33);
    frame(8'h83, 8'h33, 0, 8'h33);
    frame(8'h80, 8'h44, 0, 8'h38);
    check({frameBroadcast, frameAddr}, 8'h80);
    frame(8'h05, 8'h55, 3, 8'h33);
    frame(8'h06, 8'h66, 0, 8'h3C);
    frame(8'h05, 8'h77, 1, 8'h33);
    frame(8'h05, 8'h78, 1, 8'h33);
    frame(8'h05, 8'h79, 1, 8'h43);
    frame(8'h05, 8'h7A, 0, 8'h41);
    clear_alarms();
    check(status, 8'h31);
    for (int a = 0; a < 4; a++)
    begin
      @(negedge clock);
      stopAction = 2'(a);
      sawStop = 1'b0;
      stopFrame = 1'b1;
      @(negedge clock);
      stopFrame = 1'b0;
      repeat (3) @(negedge clock);
      check({5'h00, sawStop, stopMethod}, 8'(4 + a));
    end
    $display("stop actions done");
    frame(8'h05, 8'h12, 0, 8'h3C);
    timeoutAction = 2'h2;
    receivePeriodMs = 16'h0003;
    repeat (150) @(negedge clock);
    check({timeoutAlarm, alarmOutputLine, sawStop, 3'h0, stopMethod},
      8'hA2);
    check(errorCode, CODE_COMM_TIMEOUT);
    receivePeriodMs = 16'h0000;
    clear_alarms();
    check({7'h00, alarmOutputLine}, 8'h01);
    $display("timeout done");
    @(negedge clock) nackEvent = 1'b1;
    @(negedge clock) nackEvent = 1'b0;
    logIndex = 3'h7;
    repeat (3) @(negedge clock);
    check(logData, CODE_NACK);
    logIndex = 3'h0;
    repeat (2) @(negedge clock);
    check(logData, CODE_COMM_ERROR);
    check({4'h0, logCount}, 8'h08);
    $display("error log done");
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule : serial_link_error_supervisor_tb_top
`default_nettype wire
